// ### rtl/sac_consts.svh
/*
  Register offsets, field positions, reset values and counts for the
  converter configuration and accumulator block.
  Assumes inclusion by bare name from files under rtl/.
*/
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets on the special-function register port
// ----------------------------------------------------------------
`define SAC_OFF_CONV_CFG 8'hbc
`define SAC_OFF_ACC_CFG 8'hb3
`define SAC_OFF_PWR_CTRL 8'hdf
`define SAC_OFF_CONV_CTRL 8'he8
`define SAC_OFF_RESULT_LO 8'hbd
`define SAC_OFF_RESULT_HI 8'hbe

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SAC_RST_CONV_CFG 8'hf8
`define SAC_RST_ACC_CFG 8'h00
`define SAC_RST_PWR_CTRL 8'h0f
`define SAC_RST_CONV_CTRL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SAC_CFG_DIV_HI 7
`define SAC_CFG_DIV_LO 3
`define SAC_CFG_EIGHT 2
`define SAC_CFG_TRACK 1
`define SAC_CFG_GAIN 0
`define SAC_ACC_TWELVE 7
`define SAC_ACC_ACCUM 6
`define SAC_ACC_SJ_HI 5
`define SAC_ACC_SJ_LO 3
`define SAC_ACC_RPT_HI 2
`define SAC_ACC_RPT_LO 0
`define SAC_PWR_DLY_HI 3
`define SAC_PWR_DLY_LO 0
`define SAC_CTRL_ENABLE 7
`define SAC_CTRL_BURST 6
`define SAC_CTRL_DONE 5
`define SAC_CTRL_START 4

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define SAC_TRACK_SAR_CYCLES 3'h4
`define SAC_HFO_PER_PWR_COUNT 7'h08
`define SAC_SUBCONV_PER_12BIT 2'h3
`define SAC_SJ_LEFT 3'h4

`endif

// ### rtl/sac_pkg.sv
/*
  Types shared by the converter configuration and accumulator block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sac_pkg;
  typedef logic [7:0] sac_byte_t;
  typedef logic [15:0] sac_word_t;
  typedef logic [11:0] sac_sample_t;
  // Gray codes along idle, power-up, track, convert, finish
  typedef enum logic [2:0]
  {
    SAC_IDLE = 3'h0,
    SAC_PWRUP = 3'h1,
    SAC_TRACK = 3'h3,
    SAC_CONV = 3'h2,
    SAC_FINISH = 3'h6
  } sac_state_e;
endpackage

// ### rtl/sac_sar_divider.sv
/*
  Successive-approximation clock divider: one tick out every divide+1
  ticks of the selected converter input clock.
  Assumes both input ticks are one-cycle strobes on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_sar_divider
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic coreClkTick,
  input wire logic hfOscTick,
  input wire logic burstOn,
  input wire logic [4:0] divide,
  output logic sarTick
);
  import sac_pkg::*;
  logic [4:0] cnt;
  logic selTick;

  assign selTick = burstOn ? hfOscTick : coreClkTick;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 5'h00;
      sarTick <= 1'b0;
    end
    else
    begin
      sarTick <= selTick && (cnt >= divide);
      if (selTick)
        cnt <= (cnt >= divide) ? 5'h00 : cnt + 5'h01;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_div_period: assert property (sarTick |-> $past(selTick) && $past(cnt) >= $past(divide))
    else $error("SAR tick without full divide period");
  a_clock_source: assert property ((!burstOn && hfOscTick && !coreClkTick) |=> !sarTick)
    else $error("Oscillator tick used while burst is off");
endmodule // sac_sar_divider
`default_nettype wire

// ### rtl/sac_config_accum.sv
/*
  Converter configuration, sequencing and result accumulation with
  shift/justify formatting, reached over the special-function register port.
  Assumes the converter core, start event and clock ticks are on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.svh"
// How it works
// - SAR clock is input clock divided by divider field plus one.
// - Input clock is core clock with burst off, oscillator with burst on.
// - Eight-bit select set gives 8-bit conversions, else 10 or 12.
// - Track delay clear: conversion starts right after the start event, or after the power-up wait with burst on.
// - Track delay set: track four SAR clocks, then convert.
// - Gain select clear gives half gain, set gives unity.
// - Twelve-bit select gives 12-bit results at quarter throughput.
// - Burst off, accumulate clear: result pair holds latest conversion.
// - Burst off, accumulate set: each conversion adds into result pair.
// - Shift/justify codes 0-3 shift right, code 4 left justifies.
// - Burst repeat codes give 1,4,8,16,32,64 accumulated conversions.
// - In 12-bit mode repeat codes give a quarter as many.
// - Burst select enables burst operation.
// - Done flag set per conversion or per burst; software clears.
// - Burst power-up waits eight oscillator ticks per count.
module sac_config_accum
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] sfrAddr,
  input wire sac_pkg::sac_byte_t sfrWrData,
  input wire logic sfrWrite,
  input wire logic sfrRead,
  output sac_pkg::sac_byte_t sfrRdData,
  input wire logic coreClkTick,
  input wire logic hfOscTick,
  input wire logic startEvent,
  input wire logic coreDone,
  input wire sac_pkg::sac_sample_t coreData,
  output logic sarTick,
  output logic convStart,
  output logic eightBitMode,
  output logic twelveBitMode,
  output logic gainUnity,
  output logic converterOn,
  output logic doneFlag
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  sac_byte_t convCfg;
  sac_byte_t accCfg;
  sac_byte_t pwrCtrl;
  logic burstOn;
  logic swStart;
  logic wrCfg;
  logic wrAcc;
  logic wrPwr;
  logic wrCtrl;
  logic wrResult;
  logic [2:0] sjCode;
  logic [2:0] rptCode;
  logic trackDelay;
  logic accumSel;

  assign wrCfg = sfrWrite && (sfrAddr == `SAC_OFF_CONV_CFG);
  assign wrAcc = sfrWrite && (sfrAddr == `SAC_OFF_ACC_CFG);
  assign wrPwr = sfrWrite && (sfrAddr == `SAC_OFF_PWR_CTRL);
  assign wrCtrl = sfrWrite && (sfrAddr == `SAC_OFF_CONV_CTRL);
  assign wrResult = sfrWrite && (sfrAddr == `SAC_OFF_RESULT_HI ||
                                 sfrAddr == `SAC_OFF_RESULT_LO);
  assign sjCode = accCfg[`SAC_ACC_SJ_HI:`SAC_ACC_SJ_LO];
  assign rptCode = accCfg[`SAC_ACC_RPT_HI:`SAC_ACC_RPT_LO];
  assign trackDelay = convCfg[`SAC_CFG_TRACK];
  assign accumSel = accCfg[`SAC_ACC_ACCUM];

  // mode and gain bits drive the core
  assign eightBitMode = convCfg[`SAC_CFG_EIGHT];
  assign gainUnity = convCfg[`SAC_CFG_GAIN];
  assign twelveBitMode = accCfg[`SAC_ACC_TWELVE];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      convCfg <= `SAC_RST_CONV_CFG;
      accCfg <= `SAC_RST_ACC_CFG;
      pwrCtrl <= `SAC_RST_PWR_CTRL;
    end
    else
    begin
      if (wrCfg)
        convCfg <= sfrWrData;
      if (wrAcc)
        accCfg <= sfrWrData;
      if (wrPwr)
        pwrCtrl <= sfrWrData;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      converterOn <= 1'b0;
      burstOn <= 1'b0;
    end
    else if (wrCtrl)
    begin
      converterOn <= sfrWrData[`SAC_CTRL_ENABLE];
      burstOn <= sfrWrData[`SAC_CTRL_BURST];
    end
  end

  assign swStart = wrCtrl && sfrWrData[`SAC_CTRL_START];

  // ----------------------------------------------------------------
  // SAR clock
  // ----------------------------------------------------------------
  // divider instance
  sac_sar_divider u_div
  (
    .mclk(mclk),
    .resetn(resetn),
    .coreClkTick(coreClkTick),
    .hfOscTick(hfOscTick),
    .burstOn(burstOn),
    .divide(convCfg[`SAC_CFG_DIV_HI:`SAC_CFG_DIV_LO]),
    .sarTick(sarTick)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sac_state_e state;
  sac_state_e next_state;
  logic socTake;
  logic [6:0] pwrCnt;
  logic [6:0] pwrTarget;
  logic [2:0] trackCnt;
  logic [1:0] subCnt;
  logic [6:0] convCnt;
  logic [6:0] convTarget;
  logic resultTake;
  logic burstRun;

  // Start while busy is dropped; a new burst only begins from idle
  assign socTake = (state == SAC_IDLE) && converterOn && (startEvent || swStart);
  assign pwrTarget = pwrCtrl[`SAC_PWR_DLY_HI:`SAC_PWR_DLY_LO] * `SAC_HFO_PER_PWR_COUNT;
  assign resultTake = (state == SAC_CONV) && coreDone &&
                      (!twelveBitMode || subCnt == `SAC_SUBCONV_PER_12BIT);

  always_comb
  begin
    convTarget = 7'h01;
    if (burstRun && !twelveBitMode && rptCode != 3'h0)
      convTarget = 7'h01 << ((rptCode > 3'h5 ? 3'h5 : rptCode) + 3'h1);
    else if (burstRun && twelveBitMode && rptCode > 3'h1)
      convTarget = 7'h01 << ((rptCode > 3'h5 ? 3'h5 : rptCode) - 3'h1);
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      SAC_IDLE:
        if (socTake)
        begin
          if (burstOn)
            next_state = SAC_PWRUP;
          else if (trackDelay)
            next_state = SAC_TRACK;
          else
            next_state = SAC_CONV;
        end
      SAC_PWRUP:
        if (pwrCnt >= pwrTarget)
          next_state = trackDelay ? SAC_TRACK : SAC_CONV;
      SAC_TRACK:
        if (sarTick && trackCnt == `SAC_TRACK_SAR_CYCLES - 3'h1)
          next_state = SAC_CONV;
      SAC_CONV:
        if (resultTake)
        begin
          if (convCnt + 7'h01 >= convTarget)
            next_state = SAC_FINISH;
          else
            next_state = trackDelay ? SAC_TRACK : SAC_CONV;
        end
      SAC_FINISH:
        next_state = SAC_IDLE;
      default:
        next_state = SAC_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state <= SAC_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      burstRun <= 1'b0;
    else if (socTake)
      burstRun <= burstOn;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pwrCnt <= 7'h00;
      trackCnt <= 3'h0;
    end
    else
    begin
      pwrCnt <= (state == SAC_PWRUP && hfOscTick) ? pwrCnt + 7'h01 :
                (state == SAC_PWRUP) ? pwrCnt : 7'h00;
      trackCnt <= (state == SAC_TRACK && sarTick) ? trackCnt + 3'h1 :
                  (state == SAC_TRACK) ? trackCnt : 3'h0;
    end
  end

  // immediate start, or start on leaving track/power-up
  // four core passes per 12-bit result
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      convStart <= 1'b0;
      subCnt <= 2'h0;
    end
    else
    begin
      convStart <= (next_state == SAC_CONV) &&
                   (state != SAC_CONV || coreDone);
      if (state == SAC_CONV && coreDone)
        subCnt <= resultTake ? 2'h0 : subCnt + 2'h1;
      else if (state == SAC_IDLE)
        subCnt <= 2'h0;
    end
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      convCnt <= 7'h00;
    else if (state == SAC_IDLE)
      convCnt <= 7'h00;
    else if (resultTake)
      convCnt <= convCnt + 7'h01;
  end

  // ----------------------------------------------------------------
  // Accumulator and done flag
  // ----------------------------------------------------------------
  sac_word_t acc;
  sac_word_t sample;

  // 8-bit results use only the low byte of core data
  assign sample = eightBitMode ? {8'h00, coreData[7:0]} : {4'h0, coreData};

  // sixteen-bit sum never wraps for legal bursts
  // replace when burst off and accumulate clear
  // add when burst off and accumulate set
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      acc <= 16'h0000;
    else if (socTake && burstOn)
      acc <= 16'h0000;
    else if (resultTake)
      acc <= (burstRun || accumSel) ? acc + sample : sample;
    else if (wrResult)
      acc <= 16'h0000;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      doneFlag <= 1'b0;
    else if (state == SAC_FINISH)
      doneFlag <= 1'b1;
    else if (wrCtrl && !sfrWrData[`SAC_CTRL_DONE])
      doneFlag <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read port and result formatting
  // ----------------------------------------------------------------
  sac_word_t fmt;

  // right shift by code, or left justify by resolution
  always_comb
  begin
    fmt = acc;
    if (sjCode < `SAC_SJ_LEFT)
      fmt = acc >> sjCode;
    else if (sjCode == `SAC_SJ_LEFT)
      fmt = eightBitMode ? acc << 8 : twelveBitMode ? acc << 4 : acc << 6;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      sfrRdData <= 8'h00;
    else if (sfrRead)
    begin
      unique case (sfrAddr)
        `SAC_OFF_CONV_CFG: sfrRdData <= convCfg;
        `SAC_OFF_ACC_CFG: sfrRdData <= accCfg;
        `SAC_OFF_PWR_CTRL: sfrRdData <= pwrCtrl;
        `SAC_OFF_CONV_CTRL: sfrRdData <= {converterOn, burstOn, doneFlag,
                                         state != SAC_IDLE, 4'h0};
        `SAC_OFF_RESULT_LO: sfrRdData <= fmt[7:0];
        `SAC_OFF_RESULT_HI: sfrRdData <= fmt[15:8];
        default: sfrRdData <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_plain_start;
    socTake && !burstOn && !trackDelay;
  endsequence
  sequence s_track_exit;
    state == SAC_TRACK && next_state == SAC_CONV;
  endsequence

  a_normal_start: assert property (s_plain_start |=> convStart && state == SAC_CONV)
    else $error("Normal track did not start at once");
  a_delayed_track: assert property (s_track_exit |-> trackCnt == 3'h3 && sarTick)
    else $error("Delayed track left early");
  a_eight_mode: assert property (wrCfg && sfrWrData[2] |=> eightBitMode)
    else $error("Eight-bit select not applied");
  a_gain_select: assert property (wrCfg |=> gainUnity == $past(sfrWrData[0]))
    else $error("Gain select not applied");
  a_twelve_quarter: assert property ((state == SAC_CONV && coreDone && twelveBitMode
    && subCnt != 2'h3) |=> convStart && convCnt == $past(convCnt))
    else $error("Twelve-bit pass counted as result");
  a_replace_result: assert property ((resultTake && !burstRun && !accumSel)
    |=> acc == $past(sample))
    else $error("Result not replaced");
  a_accum_result: assert property ((resultTake && (burstRun || accumSel))
    |=> acc == $past(acc) + $past(sample))
    else $error("Result not accumulated");
  a_read_shift: assert property ((sfrRead && sfrAddr == `SAC_OFF_RESULT_LO && sjCode == 3'h1)
    |=> sfrRdData == $past(acc[8:1]))
    else $error("Shifted read wrong");
  a_burst_count: assert property (state == SAC_FINISH |-> convCnt == convTarget)
    else $error("Burst count mismatch");
  a_done_set: assert property (state == SAC_FINISH |=> doneFlag)
    else $error("Done flag not set");
  a_power_wait: assert property ((state == SAC_PWRUP && next_state != SAC_PWRUP)
    |-> pwrCnt >= pwrTarget)
    else $error("Power-up wait cut short");
endmodule // sac_config_accum
`default_nettype wire

// ### sim/sac_core_model.sv
/*
  Behavioural converter core: answers each convStart with one coreDone pulse
  and a sample, after a latency chosen by the bench.
  Assumes convStart is a one-cycle pulse on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sac_core_model
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic convStart,
  input wire logic [3:0] latency,
  input wire sac_pkg::sac_sample_t sample,
  output logic coreDone,
  output sac_pkg::sac_sample_t coreData
);
  import sac_pkg::*;
  logic busy;
  logic [3:0] left;
  // ----------------------------------------------------------------
  // One answer per start
  // ----------------------------------------------------------------
  // Data flips outside coreDone so a stale read cannot pass by luck
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      left <= 4'h0;
      coreDone <= 1'b0;
      coreData <= 12'h000;
    end
    else
    begin
      coreDone <= 1'b0;
      coreData <= ~coreData;
      if (convStart)
      begin
        busy <= 1'b1;
        left <= latency;
      end
      else if (busy && left == 4'h0)
      begin
        busy <= 1'b0;
        coreDone <= 1'b1;
        coreData <= sample;
      end
      else if (busy)
        left <= left - 4'h1;
    end
  end
endmodule // sac_core_model
`default_nettype wire

// ### sim/tb_sac_config_accum.sv
/*
  Self-checking bench for sac_config_accum with a behavioural core.
  Assumes the rtl/ files and sim/sac_core_model.sv are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.svh"
module tb_sac_config_accum;
  import sac_pkg::*;
  logic mclk, resetn, sfrWrite, sfrRead, coreClkTick, hfOscTick, startEvent;
  logic coreDone, sarTick, convStart, eightBitMode, twelveBitMode;
  logic gainUnity, converterOn, doneFlag;
  logic [7:0] sfrAddr;
  logic [3:0] latency;
  sac_byte_t sfrWrData, sfrRdData;
  sac_sample_t coreData, sample;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  sac_config_accum dut (.mclk(mclk), .resetn(resetn), .sfrAddr(sfrAddr),
    .sfrWrData(sfrWrData), .sfrWrite(sfrWrite), .sfrRead(sfrRead),
    .sfrRdData(sfrRdData), .coreClkTick(coreClkTick), .hfOscTick(hfOscTick),
    .startEvent(startEvent), .coreDone(coreDone), .coreData(coreData),
    .sarTick(sarTick), .convStart(convStart), .eightBitMode(eightBitMode),
    .twelveBitMode(twelveBitMode), .gainUnity(gainUnity),
    .converterOn(converterOn), .doneFlag(doneFlag));
  sac_core_model core (.mclk(mclk), .resetn(resetn), .convStart(convStart),
    .latency(latency), .sample(sample), .coreDone(coreDone), .coreData(coreData));

  // ----------------------------------------------------------------
  // Clock, oscillator ticks and timeout
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Oscillator tick every other cycle so burst halves the SAR rate
  always @(posedge mclk)
  begin
    #10;
    hfOscTick = ~hfOscTick;
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, input sac_byte_t d);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    tick();
    sfrWrite = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [7:0] a, output sac_byte_t d);
    sfrAddr = a;
    sfrRead = 1'b1;
    tick();
    sfrRead = 1'b0;
    d = sfrRdData;
    tick();
  endtask
  // Runs one start and judges count, done flag and formatted result
  task automatic conv(input sac_byte_t c, input int n, input logic [15:0] e,
    output int pre, output int sarN);
    int k, s;
    logic [15:0] r;
    s = 0;
    pre = -1;
    sarN = 0;
    wr(`SAC_OFF_CONV_CTRL, c);
    startEvent = 1'b1;
    tick();
    startEvent = 1'b0;
    for (k = 0; k < 3000 && doneFlag !== 1'b1; k++)
    begin
      if (convStart === 1'b1)
      begin
        if (s == 0)
          pre = k;
        s++;
      end
      else if (s == 0)
        sarN += (sarTick === 1'b1);
      tick();
    end
    chk(16'(doneFlag), 16'h0001);
    chk(16'(s), 16'(n));
    wr(`SAC_OFF_CONV_CTRL, c);
    chk(16'(doneFlag), 16'h0000);
    rd(`SAC_OFF_RESULT_LO, r[7:0]);
    rd(`SAC_OFF_RESULT_HI, r[15:8]);
    chk(r, e);
  endtask
  task automatic period(output int p);
    int k;
    repeat (20) tick();
    for (k = 0; k < 200 && sarTick !== 1'b1; k++)
      tick();
    tick();
    for (p = 1; p < 200 && sarTick !== 1'b1; p++)
      tick();
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    sac_byte_t d;
    rd(`SAC_OFF_CONV_CFG, d);
    chk(16'(d), 16'h00f8);
    rd(`SAC_OFF_ACC_CFG, d);
    chk(16'(d), 16'h0000);
    rd(`SAC_OFF_PWR_CTRL, d);
    chk(16'(d), 16'h000f);
    rd(8'h00, d);
    chk(16'(d), 16'h0000);
  endtask
  task automatic s_modes();
    sac_byte_t d;
    wr(`SAC_OFF_CONV_CFG, 8'h15);
    rd(`SAC_OFF_CONV_CFG, d);
    chk(16'(d), 16'h0015);
    chk(16'(eightBitMode), 16'h0001);
    chk(16'(gainUnity), 16'h0001);
    wr(`SAC_OFF_ACC_CFG, 8'h80);
    chk(16'(twelveBitMode), 16'h0001);
    wr(`SAC_OFF_ACC_CFG, 8'h00);
    wr(`SAC_OFF_CONV_CFG, 8'h10);
    chk(16'(gainUnity), 16'h0000);
  endtask
  task automatic s_divider();
    int p, s;
    wr(`SAC_OFF_CONV_CTRL, 8'h80);
    period(p);
    chk(16'(p), 16'h0003);
    wr(`SAC_OFF_CONV_CTRL, 8'hc0);
    period(p);
    chk(16'(p), 16'h0006);
    // Core clock stopped with burst off: oscillator ticks must not reach the divider
    wr(`SAC_OFF_CONV_CTRL, 8'h80);
    coreClkTick = 1'b0;
    tick();
    s = 0;
    repeat (20)
    begin
      s += (sarTick === 1'b1);
      tick();
    end
    chk(16'(s), 16'h0000);
    coreClkTick = 1'b1;
  endtask
  task automatic s_refuse();
    int k, s;
    sac_byte_t d;
    wr(`SAC_OFF_CONV_CTRL, 8'h00);
    startEvent = 1'b1;
    tick();
    startEvent = 1'b0;
    s = 0;
    for (k = 0; k < 20; k++)
    begin
      s += (convStart === 1'b1);
      tick();
    end
    chk(16'(s), 16'h0000);
    chk(16'(converterOn), 16'h0000);
    // Start by register write once enabled; busy reads clear, done set afterwards
    wr(`SAC_OFF_CONV_CTRL, 8'h80);
    wr(`SAC_OFF_CONV_CTRL, 8'h90);
    repeat (20) tick();
    rd(`SAC_OFF_CONV_CTRL, d);
    chk(16'(d), 16'h00a0);
  endtask
  task automatic s_single();
    int p, a;
    // divider field kept at 2, one SAR clock per three core clocks
    wr(`SAC_OFF_CONV_CFG, 8'h10);
    conv(8'h80, 1, 16'h02a5, p, a);
    chk(16'(p), 16'h0000);
    wr(`SAC_OFF_CONV_CFG, 8'h14);
    conv(8'h80, 1, 16'h00a5, p, a);
    latency = 4'h7;
    wr(`SAC_OFF_CONV_CFG, 8'h12);
    conv(8'h80, 1, 16'h02a5, p, a);
    chk(16'(a), 16'h0004);
    latency = 4'h0;
    wr(`SAC_OFF_CONV_CFG, 8'h10);
  endtask
  task automatic s_justify();
    int p, a, c;
    for (c = 0; c < 5; c++)
    begin
      wr(`SAC_OFF_ACC_CFG, 8'(c << 3));
      conv(8'h80, 1, (c == 4) ? 16'ha940 : 16'h02a5 >> c, p, a);
    end
  endtask
  task automatic s_accum();
    int p, a;
    wr(`SAC_OFF_ACC_CFG, 8'h40);
    wr(`SAC_OFF_RESULT_LO, 8'h00);
    conv(8'h80, 1, 16'h02a5, p, a);
    conv(8'h80, 1, 16'h054a, p, a);
  endtask
  task automatic s_burst();
    int p, a, c, t, r, n;
    sac_byte_t d;
    wr(`SAC_OFF_PWR_CTRL, 8'h02);
    rd(`SAC_OFF_PWR_CTRL, d);
    chk(16'(d), 16'h0002);
    for (c = 0; c < 11; c++)
    begin
      t = (c > 5);
      r = t ? c - 5 : c;
      n = (r == 0) ? 1 : 1 << (r + 1);
      sample = t ? 12'habc : 12'h2a5;
      wr(`SAC_OFF_ACC_CFG, {t[0], 4'h0, r[2:0]});
      conv(8'hc0, n, t ? 16'((n / 4) * 'habc) : 16'(n * 'h2a5), p, a);
      chk(16'(p >= 32), 16'h0001);
    end
    sample = 12'h2a5;
    // repeat field back to zero before burst goes off
    wr(`SAC_OFF_ACC_CFG, 8'h00);
    wr(`SAC_OFF_CONV_CTRL, 8'h80);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    sfrWrite = 1'b0;
    sfrRead = 1'b0;
    coreClkTick = 1'b1;
    hfOscTick = 1'b0;
    startEvent = 1'b0;
    latency = 4'h0;
    sample = 12'h2a5;
    repeat (6) @(posedge mclk);
    #10;
    resetn = 1'b1;
    s_reset();
    s_modes();
    s_divider();
    s_refuse();
    s_single();
    s_justify();
    s_accum();
    s_burst();
    test_done();
  end
endmodule // tb_sac_config_accum
`default_nettype wire
